// ---- rtl/spbs_cfg.svh ----
/*
 constants for the pipelined burst sram model: widths, lane layout,
 sleep timing. assumes a 40 MHz clk.
*/
`ifndef SPBS_CFG_SVH
`define SPBS_CFG_SVH
`define SPBS_AW            16
`define SPBS_DW            32
`define SPBS_LANES         4
`define SPBS_LANE_W        8
`define SPBS_DEPTH         65536
`define SPBS_CLK_PERIOD_NS 25
`define SPBS_SLEEP_CYC     2
`define SPBS_SLEEP_CNT_W   2
`define SPBS_ALL_LANES     4'hf
`define SPBS_NO_LANES      4'h0
`define SPBS_LANES_OFF_N   4'hf
`endif

// ---- rtl/spbs_pkg.sv ----
/*
 types for the pipelined burst sram model.
 assumes spbs_cfg.svh supplies the numbers.
*/
package spbs_pkg;
	typedef enum logic [1:0] {
		SPBS_IDLE   = 2'b00,
		SPBS_READ   = 2'b01,
		SPBS_WRITE  = 2'b10,
		SPBS_SLEEP  = 2'b11
	} spbs_cyc_t;
endpackage

// ---- rtl/spbs_mem.sv ----
/*
 64k x 32 storage with per-lane write enables and a registered read port.
 assumes one synchronous clock; read data lags the address by one edge.
*/
`timescale 1ns/1ps
`include "spbs_cfg.svh"
module spbs_mem (
	input  wire logic                       clk,
	input  wire logic [`SPBS_AW-1:0]        addr,
	input  wire logic [`SPBS_LANES-1:0]     lane_we,
	input  wire logic [`SPBS_DW-1:0]        wdata,
	output logic      [`SPBS_DW-1:0]        rdata_ff
);
	logic [`SPBS_DW-1:0] mem [0:`SPBS_DEPTH-1];

	always_ff @(posedge clk) begin
		rdata_ff <= mem[addr];
	end

	genvar g;
	generate
		for (g = 0; g < `SPBS_LANES; g++) begin : gen_lane
			always_ff @(posedge clk) begin
				if (lane_we[g]) begin
					mem[addr][g*`SPBS_LANE_W +: `SPBS_LANE_W] <=
						wdata[g*`SPBS_LANE_W +: `SPBS_LANE_W];
				end
			end
		end
	endgenerate
endmodule

// ---- rtl/spbs_burst_ctr.sv ----
/*
 two-bit wraparound burst counter, interleaved or linear order.
 assumes load and step are never asserted together by the caller.
*/
`timescale 1ns/1ps
`include "spbs_cfg.svh"
module spbs_burst_ctr (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       load,
	input  wire logic       step,
	input  wire logic       interleaved,
	input  wire logic [1:0] start,
	output logic      [1:0] low_addr
);
	logic [1:0] base_ff;
	logic [1:0] cnt_ff;
	logic [1:0] nxt_base;
	logic [1:0] nxt_cnt;

	assign nxt_base = load ? start : base_ff;
	assign nxt_cnt  = load ? 2'h0 : (step ? 2'(cnt_ff + 2'h1) : cnt_ff);
	// xor for interleaved, modulo-four add for linear
	assign low_addr = interleaved ? (base_ff ^ cnt_ff)
	                              : 2'(base_ff + cnt_ff);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			base_ff <= 2'h0;
			cnt_ff  <= 2'h0;
		end else begin
			base_ff <= nxt_base;
			cnt_ff  <= nxt_cnt;
		end
	end
endmodule

// ---- rtl/spbs_top.sv ----
/*
 synchronous pipelined burst sram, 64k x 32, common data bus.
 assumes inputs synchronous to clk; the pad ring resolves dq from
 dq_out, dq_oe_n and the far driver. sleep_request is resynchronised.
*/
`timescale 1ns/1ps
`include "spbs_cfg.svh"
// Function
// - read starts on strobe, selected, no write
// - processor strobe ignored if first select high, except that it still blocks advance
// - read data appears one edge later
// - first cycle after deselect stays hi-z
// - back-to-back reads; deselect floats bus on the next edge
// - processor start ignores write and advance inputs
// - processor write completes on second edge
// - global write all bytes, else selected lanes
// - write cycle forces bus hi-z
// - controller strobe single-cycle write
// - advance ignored on controller strobe cycle
// - two-bit counter loaded from low address
// - advance low steps counter when strobes idle
// - interleaved order xors count into start
// - linear order adds count modulo four
// - strap selects burst order
// - strobes and advance high hold address
// - output enable gates drivers asynchronously
// - sleep takes two cycles, keeps data, hi-z
// - strap low linear, high interleaved
// - processor strobe begins read whenever awake and all selects active
// - global write overrides; lane i is byte i
module spbs_top (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic [`SPBS_AW-1:0]    addr,
	input  wire logic                   processor_addr_strobe_n,
	input  wire logic                   controller_addr_strobe_n,
	input  wire logic                   burst_advance_n,
	input  wire logic                   chip_sel_first_n,
	input  wire logic                   chip_sel_second,
	input  wire logic                   chip_sel_third_n,
	input  wire logic                   global_write_n,
	input  wire logic                   byte_write_enable_n,
	input  wire logic [`SPBS_LANES-1:0] byte_lane_select_n,
	input  wire logic                   output_enable_n,
	input  wire logic                   burst_order,
	input  wire logic                   sleep_request,
	input  wire logic [`SPBS_DW-1:0]    dq_in,
	output logic      [`SPBS_DW-1:0]    dq_out,
	output logic                        dq_oe_n,
	output logic                        asleep
);
	spbs_pkg::spbs_cyc_t cyc_ff;
	spbs_pkg::spbs_cyc_t nxt_cyc;

	logic [`SPBS_AW-1:0]          addr_ff;
	logic [`SPBS_AW-1:0]          nxt_addr;
	logic                         first_ff;
	logic                         nxt_first;
	logic                         sleep_meta_ff;
	logic                         sleep_sync_ff;
	logic [`SPBS_SLEEP_CNT_W-1:0] sleep_cnt_ff;
	logic [`SPBS_SLEEP_CNT_W-1:0] nxt_sleep_cnt;
	logic                         asleep_ff;
	logic                         nxt_asleep;
	logic                         order_ff;
	logic                         order_taken_ff;

	// select and strobe decode
	wire all_sel   = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
	wire proc_stb  = !processor_addr_strobe_n && !chip_sel_first_n;
	wire ctrl_stb  = !controller_addr_strobe_n && !proc_stb;
	wire any_stb   = proc_stb || ctrl_stb;
	wire awake     = !asleep_ff;
	wire start_acc = awake && any_stb && all_sel;
	wire deselect  = awake && any_stb && !all_sel;
	wire no_stb    = processor_addr_strobe_n && controller_addr_strobe_n;
	wire idle_stb  = awake && !any_stb;
	// only a live read or write burst continues; sleep exit goes idle
	wire in_burst  = (cyc_ff == spbs_pkg::SPBS_READ) || (cyc_ff == spbs_pkg::SPBS_WRITE);
	wire adv_step  = idle_stb && no_stb && !burst_advance_n;
	wire wr_req    = !global_write_n || (!byte_write_enable_n &&
	                 (byte_lane_select_n != `SPBS_LANES_OFF_N));
	// processor start is always a read, controls ignored
	wire start_rd  = start_acc && (proc_stb || !wr_req);
	wire start_wr  = start_acc && ctrl_stb && wr_req;
	wire cont_wr   = idle_stb && in_burst && wr_req;
	wire cont_rd   = idle_stb && in_burst && !wr_req;

	// global write overrides lane selects
	wire [`SPBS_LANES-1:0] lanes = !global_write_n ? `SPBS_ALL_LANES
	                             : (!byte_write_enable_n ? ~byte_lane_select_n
	                                                     : `SPBS_NO_LANES);
	wire do_write              = start_wr || cont_wr;
	wire [`SPBS_LANES-1:0] we  = do_write ? lanes : `SPBS_NO_LANES;

	// strap taken once after reset release
	wire interleaved = order_taken_ff ? order_ff : burst_order;
	wire [1:0] low_addr;
	wire [`SPBS_AW-1:0] cur_addr = {addr_ff[`SPBS_AW-1:2], low_addr};
	// reads use the captured address, so data leaves one edge after capture
	wire [`SPBS_AW-1:0] mem_addr = start_wr ? addr : cur_addr;

	assign nxt_addr = start_acc ? addr : addr_ff;

	// cycle type tracking
	always_comb begin
		nxt_cyc = cyc_ff;
		if (asleep_ff) begin
			nxt_cyc = spbs_pkg::SPBS_SLEEP;
		end else if (deselect) begin
			nxt_cyc = spbs_pkg::SPBS_IDLE;
		end else if (start_wr) begin
			nxt_cyc = spbs_pkg::SPBS_WRITE;
		end else if (start_rd) begin
			nxt_cyc = spbs_pkg::SPBS_READ;
		end else if (cont_wr) begin
			nxt_cyc = spbs_pkg::SPBS_WRITE;
		end else if (cont_rd) begin
			nxt_cyc = spbs_pkg::SPBS_READ;
		end else if (cyc_ff == spbs_pkg::SPBS_SLEEP) begin
			nxt_cyc = spbs_pkg::SPBS_IDLE;
		end
	end

	// first cycle out of deselect is masked
	assign nxt_first = start_rd && (cyc_ff != spbs_pkg::SPBS_READ);

	// sleep entry and exit take two cycles
	assign nxt_sleep_cnt = (sleep_sync_ff == asleep_ff) ? '0
	                     : 2'(sleep_cnt_ff + 2'h1);
	assign nxt_asleep    = (sleep_sync_ff != asleep_ff) &&
	                       (nxt_sleep_cnt == 2'(`SPBS_SLEEP_CYC)) ? sleep_sync_ff
	                                                             : asleep_ff;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cyc_ff         <= spbs_pkg::SPBS_IDLE;
			addr_ff        <= '0;
			first_ff       <= 1'b0;
			sleep_meta_ff  <= 1'b0;
			sleep_sync_ff  <= 1'b0;
			sleep_cnt_ff   <= '0;
			asleep_ff      <= 1'b0;
			order_ff       <= 1'b1;
			order_taken_ff <= 1'b0;
		end else begin
			cyc_ff         <= nxt_cyc;
			addr_ff        <= nxt_addr;
			first_ff       <= nxt_first;
			sleep_meta_ff  <= sleep_request;
			sleep_sync_ff  <= sleep_meta_ff;
			sleep_cnt_ff   <= (nxt_asleep != asleep_ff) ? '0 : nxt_sleep_cnt;
			asleep_ff      <= nxt_asleep;
			order_ff       <= order_taken_ff ? order_ff : burst_order;
			order_taken_ff <= 1'b1;
		end
	end

	spbs_burst_ctr u_ctr (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.load        (start_acc),
		.step        (adv_step),
		.interleaved (interleaved),
		.start       (addr[1:0]),
		.low_addr    (low_addr)
	);

	spbs_mem u_mem (
		.clk      (clk),
		.addr     (mem_addr),
		.lane_we  (we),
		.wdata    (dq_in),
		.rdata_ff (dq_out)
	);

	// output enable is combinational, never sampled
	assign dq_oe_n = output_enable_n || (cyc_ff != spbs_pkg::SPBS_READ) ||
	                 first_ff || asleep_ff || do_write;
	assign asleep  = asleep_ff;

	a_desel_float: assert property (@(posedge clk) disable iff (sys_rst)
		deselect |=> dq_oe_n)
		else $error("bus driven after deselect");
	a_first_masked: assert property (@(posedge clk) disable iff (sys_rst)
		(start_rd && cyc_ff == spbs_pkg::SPBS_IDLE) |=> dq_oe_n)
		else $error("first read cycle not masked");
	a_write_float: assert property (@(posedge clk) disable iff (sys_rst)
		(cyc_ff == spbs_pkg::SPBS_WRITE) |-> dq_oe_n)
		else $error("bus driven during write");
	a_proc_reads: assert property (@(posedge clk) disable iff (sys_rst)
		(awake && proc_stb && all_sel) |=> cyc_ff == spbs_pkg::SPBS_READ)
		else $error("processor strobe did not start read");
	a_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst)
		(start_acc && ctrl_stb && !global_write_n) |-> we == `SPBS_ALL_LANES)
		else $error("controller global write missed");
	a_ce1_ignore: assert property (@(posedge clk) disable iff (sys_rst)
		(chip_sel_first_n && controller_addr_strobe_n) |=> $stable(addr_ff))
		else $error("processor strobe honoured while deselected");
	a_sleep_float: assert property (@(posedge clk) disable iff (sys_rst)
		asleep_ff |-> dq_oe_n && we == `SPBS_NO_LANES)
		else $error("activity while asleep");
	a_sleep_enter: assert property (@(posedge clk) disable iff (sys_rst)
		($rose(sleep_sync_ff) && !asleep_ff) ##1 sleep_sync_ff |=> asleep_ff)
		else $error("sleep entry not two cycles");
	a_hold_addr: assert property (@(posedge clk) disable iff (sys_rst)
		(idle_stb && no_stb && burst_advance_n) |=> $stable(low_addr))
		else $error("address moved on suspend");
	a_read_drive: assert property (@(posedge clk) disable iff (sys_rst)
		(cyc_ff == spbs_pkg::SPBS_READ && !first_ff && !output_enable_n &&
		 !asleep_ff && !do_write) |-> !dq_oe_n)
		else $error("read data not driven");
	a_burst_load: assert property (@(posedge clk) disable iff (sys_rst)
		start_acc |=> low_addr == $past(addr[1:0]))
		else $error("burst counter not loaded");
	a_burst_step: assert property (@(posedge clk) disable iff (sys_rst)
		adv_step |=> low_addr != $past(low_addr))
		else $error("burst counter did not step");
	a_oe_release: assert property (@(posedge clk) disable iff (sys_rst)
		output_enable_n |-> dq_oe_n)
		else $error("bus driven with output enable high");
	a_lane_write: assert property (@(posedge clk) disable iff (sys_rst)
		(do_write && global_write_n && !byte_write_enable_n) |-> we == ~byte_lane_select_n)
		else $error("lane write mismatch");
	a_start_read: assert property (@(posedge clk) disable iff (sys_rst)
		start_rd |-> we == `SPBS_NO_LANES)
		else $error("write on read start");

	c_read:  cover property (@(posedge clk) start_rd ##1 !dq_oe_n);
	c_write: cover property (@(posedge clk) start_wr);
	c_burst: cover property (@(posedge clk) start_acc ##1 adv_step ##1 adv_step ##1 adv_step);
	c_sleep: cover property (@(posedge clk) !asleep_ff ##1 asleep_ff);
endmodule

// ---- bench/spbs_host_bus.sv ----
/*
 far-side bus model: resolves the shared data bus for the sram.
 assumes the host drives data only while the device is released.
*/
`timescale 1ns/1ps
`include "spbs_cfg.svh"
module spbs_host_bus (
	input  wire logic                clk,
	input  wire logic                host_drive,
	input  wire logic [`SPBS_DW-1:0] host_data,
	input  wire logic [`SPBS_DW-1:0] dq_out,
	input  wire logic                dq_oe_n,
	output logic      [`SPBS_DW-1:0] bus
);
	logic [`SPBS_DW-1:0] float_ff = 32'h5a5aa5a5;
	// undriven bus wanders every cycle
	always @(posedge clk) float_ff <= ~float_ff;
	// host data only with enable high
	assign bus = !dq_oe_n ? dq_out : (host_drive ? host_data : float_ff);
endmodule

// ---- bench/testbench.sv ----
/*
 self-checking bench for spbs_top: writes, byte lanes, bursts, sleep.
 assumes the model in spbs_host_bus.sv resolves the data bus.
*/
`timescale 1ns/1ps
`include "spbs_cfg.svh"
module testbench;
	logic clk = 0, sys_rst = 1, pstb_n = 1, cstb_n = 1, step_n = 1;
	logic sel1_n = 1, sel2 = 1, sel3_n = 0, allw_n = 1, lanew_n = 1;
	logic oen = 1, order = 1, slp = 0, hdrv = 0, dq_oe_n, asleep;
	logic [15:0] addr = 0;
	logic [3:0]  lanes_n = 4'hf;
	logic [31:0] hdata = 0, bus, dq_out;
	logic [31:0] mem [0:255];
	logic [31:0] expq [$];
	int          n_errors = 0, checks_done = 0;

	always #12.5 clk = ~clk;

	spbs_top u_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
		.processor_addr_strobe_n(pstb_n), .controller_addr_strobe_n(cstb_n),
		.burst_advance_n(step_n), .chip_sel_first_n(sel1_n),
		.chip_sel_second(sel2), .chip_sel_third_n(sel3_n),
		.global_write_n(allw_n), .byte_write_enable_n(lanew_n),
		.byte_lane_select_n(lanes_n), .output_enable_n(oen),
		.burst_order(order), .sleep_request(slp), .dq_in(bus),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .asleep(asleep));
	spbs_host_bus u_bus (.clk(clk), .host_drive(hdrv), .host_data(hdata),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .bus(bus));

	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic summarize();
		if (expq.size() != 0) n_errors++;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// deselect edge: controller strobe with first select high
	task automatic idle();
		pstb_n = 1; cstb_n = 0; sel1_n = 1; step_n = 1; allw_n = 1;
		lanew_n = 1; lanes_n = 4'hf; hdrv = 0; oen = 1;
		tick();
	endtask
	function automatic void upd(logic [15:0] a, logic [31:0] d, logic [3:0] ln, logic al);
		for (int i = 0; i < 4; i++)
			if (!al || !ln[i]) mem[a[7:0]][8*i+:8] = d[8*i+:8];
	endfunction
	task automatic cwrite(logic [15:0] a, logic [31:0] d, logic [3:0] ln, logic al);
		addr = a; cstb_n = 0; sel1_n = 0; allw_n = al; lanew_n = 0; lanes_n = ln;
		hdrv = 1; hdata = d; step_n = 0;
		tick();
		upd(a, d, ln, al);
	endtask
	task automatic pwrite(logic [15:0] a, logic [31:0] d, logic [3:0] ln);
		addr = a; pstb_n = 0; sel1_n = 0; cstb_n = 1; allw_n = 0; step_n = 0;
		tick();
		pstb_n = 1; allw_n = 1; lanew_n = 0; lanes_n = ln; step_n = 1;
		hdrv = 1; hdata = d; oen = 1;
		tick();
		upd(a, d, ln, 1'b1);
		idle();
	endtask
	task automatic bread(logic [15:0] a);
		logic [1:0] s;
		addr = a; pstb_n = 0; sel1_n = 0; cstb_n = 1; oen = 0;
		tick();
		pstb_n = 1; step_n = 0;
		for (int i = 0; i < 3; i++) begin
			s = order ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0];
			expq.push_back(mem[{a[7:2], s}]);
			tick();
		end
		step_n = 1; pstb_n = 0; sel1_n = 1; addr = a + 16'h0010;
		s = order ? a[1:0] ^ 2'h3 : a[1:0] + 2'h3;
		expq.push_back(mem[{a[7:2], s}]);
		tick();
		pstb_n = 1; cstb_n = 0;
		tick();
		idle();
	endtask

	always @(negedge clk)
		if (!sys_rst && dq_oe_n !== 1'b1) begin
			if (expq.size() > 0) chk(expq.pop_front(), bus);
			else chk(32'h1, {31'h0, dq_oe_n});
		end

	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		summarize();
	end

	initial begin
		void'($urandom(90));
		for (int o = 1; o >= 0; o--) begin
			order = o[0];
			sys_rst = 1;
			repeat (3) tick();
			sys_rst = 0;
			idle();
			for (int k = 0; k < 4; k++) cwrite(16'h0040 + 16'(k), $urandom, 4'hf, 1'b0);
			idle();
			pwrite(16'h0041, $urandom, 4'($urandom));
			cwrite(16'h0042, $urandom, 4'($urandom), 1'b1);
			idle();
			for (int k = 0; k < 4; k++) bread(16'h0040 + 16'(k));
		end
		cstb_n = 1;
		slp = 1;
		oen = 0;
		for (int w = 0; w < 8 && asleep !== 1'b1; w++) tick();
		chk(32'h1, {31'h0, asleep});
		repeat (3) tick();
		slp = 0;
		for (int w = 0; w < 8 && asleep !== 1'b0; w++) tick();
		chk(32'h0, {31'h0, asleep});
		oen = 1;
		repeat (2) tick();
		bread(16'h0042);
		summarize();
	end
endmodule
